// ---- rtl/cicd_core.sv ----
`timescale 1ns/1ps
`include "cicd_params.svh"
// Overview of operation
// - Literal call pushes PC plus one first.
// - Literal call forms PC from literal, latch.
// - Literal call takes two cycles.
// - Accumulator call pushes, PC from accumulator, latch.
// - Accumulator call takes two cycles.
// - Watchdog restart clears counter, prescaler, sets flags.
// - File clear writes zero, sets zero flag.
// - Accumulator clear writes zero, sets zero.
// - Decrement file into chosen destination, update zero.
// - Decrement-skip: no flags, skip when zero.
module cicd_core #(
  parameter int PC_W = `CICD_PC_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction issue
  input wire logic issue_valid,
  input cicd_pkg::cicd_op_type issue_op,
  input wire logic [`CICD_LIT_W-1:0] issue_literal,
  input wire logic [`CICD_FADDR_W-1:0] issue_faddr,
  input wire logic issue_dest,
  output logic issue_ready,
  // Machine state inputs
  input wire logic [7:0] pc_upper_latch,
  input wire logic [7:0] file_rdata,
  input wire logic watchdog_tick,
  // File register write port
  output logic file_we,
  output logic [`CICD_FADDR_W-1:0] file_waddr,
  output logic [7:0] file_wdata,
  // Return stack push port
  output logic stack_push,
  output logic [PC_W-1:0] return_stack_top,
  // Architectural state
  output logic [PC_W-1:0] pc,
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic watchdog_expiry_flag_n,
  output logic sleep_entry_flag_n,
  output logic [`CICD_WDT_W-1:0] watchdog_counter,
  output logic [`CICD_PRE_W-1:0] watchdog_prescaler,
  // Next instruction is discarded
  output logic skip_next
);
  cicd_pkg::cicd_state_type state_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] acc_q;
  logic z_q;
  logic to_n_q;
  logic pd_n_q;
  logic [`CICD_WDT_W-1:0] wdt_q;
  logic [`CICD_PRE_W-1:0] pre_q;
  logic we_q;
  logic [`CICD_FADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic push_q;
  logic [PC_W-1:0] tos_q;
  logic skip_q;
  logic take;
  logic two_cycle;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] pc_next;
  logic is_call;
  logic is_skip;
  logic writes_acc;
  logic writes_file;
  logic wdt_restart;
  logic pre_wrap;

  cicd_alu_if alu_bus ();
  assign alu_bus.op = issue_op;
  assign alu_bus.operand = file_rdata;
  cicd_alu u_alu (
    .a(alu_bus)
  );

  assign issue_ready = (state_q == cicd_pkg::CICD_ST_IDLE);
  assign take = issue_valid && issue_ready;
  assign pc_inc = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  // Restart wins over a tick in the same cycle
  assign wdt_restart = take && (issue_op == cicd_pkg::CICD_OP_WATCHDOG_RESTART);
  // Counter steps once per full prescaler cycle
  assign pre_wrap = watchdog_tick && (&pre_q);

  // Per-opcode attributes, decoded once; PC target, zero flag and watchdog restart decode issue_op on their own
  always_comb begin
    is_call = 1'b0;
    is_skip = 1'b0;
    writes_acc = 1'b0;
    writes_file = 1'b0;
    case (issue_op)
      cicd_pkg::CICD_OP_SUBROUTINE_JUMP_LIT,
      cicd_pkg::CICD_OP_SUBROUTINE_JUMP_ACC: begin
        is_call = 1'b1;
      end
      cicd_pkg::CICD_OP_FILE_ZERO: begin
        writes_file = 1'b1;
      end
      cicd_pkg::CICD_OP_ACCUMULATOR_ZERO: begin
        writes_acc = 1'b1;
      end
      cicd_pkg::CICD_OP_FILE_INVERT,
      cicd_pkg::CICD_OP_FILE_DECREMENT: begin
        writes_acc = !issue_dest;
        writes_file = issue_dest;
      end
      cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP: begin
        writes_acc = !issue_dest;
        writes_file = issue_dest;
        is_skip = alu_bus.zero;
      end
      default: begin
      end
    endcase
  end

  // two-cycle ops
  // Second slot of a call or skip is the flushed fetch
  assign two_cycle = is_call || is_skip;

  // Second cycle is the flushed slot; no new issue accepted
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= cicd_pkg::CICD_ST_IDLE;
    end else if (take && two_cycle) begin
      state_q <= cicd_pkg::CICD_ST_SECOND;
    end else begin
      state_q <= cicd_pkg::CICD_ST_IDLE;
    end
  end

  // Next program counter for a taken instruction
  always_comb begin
    pc_next = pc_inc;
    case (issue_op)
      cicd_pkg::CICD_OP_SUBROUTINE_JUMP_LIT: begin
        pc_next = PC_W'({pc_upper_latch[`CICD_LATCH_CALL_HI:`CICD_LATCH_CALL_LO],
          issue_literal[`CICD_LIT_HI:0]});
      end
      cicd_pkg::CICD_OP_SUBROUTINE_JUMP_ACC: begin
        pc_next = PC_W'({pc_upper_latch[`CICD_LATCH_ACALL_HI:0], acc_q});
      end
      cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP: begin
        pc_next = is_skip ? pc_inc + {{(PC_W-1){1'b0}}, 1'b1} : pc_inc;
      end
      default: begin
        pc_next = pc_inc;
      end
    endcase
  end

  // Program counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_q <= `CICD_PC_RESET;
    end else if (take) begin
      pc_q <= pc_next;
    end
  end

  // Return stack push pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      push_q <= 1'b0;
    end else begin
      push_q <= take && is_call;
    end
  end

  // Stack top holds PC plus one of the taken instruction
  // Only meaningful while stack_push is high
  always_ff @(posedge mclk) begin
    if (rst) begin
      tos_q <= `CICD_PC_RESET;
    end else if (take) begin
      tos_q <= pc_inc;
    end
  end

  // Accumulator destination
  // Calls read the accumulator before this edge updates it
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q <= `CICD_ACC_RESET;
    end else if (take && writes_acc) begin
      acc_q <= alu_bus.result;
    end
  end

  // File register write port
  // Stale address and data are harmless while file_we is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= `CICD_ZERO_BYTE;
    end else begin
      we_q <= take && writes_file;
      if (take) begin
        waddr_q <= issue_faddr;
        wdata_q <= alu_bus.result;
      end
    end
  end

  // Zero flag; calls and decrement-skip leave it alone
  // Watchdog restart keeps it as well
  always_ff @(posedge mclk) begin
    if (rst) begin
      z_q <= 1'b0;
    end else if (take) begin
      case (issue_op)
        cicd_pkg::CICD_OP_FILE_ZERO,
        cicd_pkg::CICD_OP_ACCUMULATOR_ZERO,
        cicd_pkg::CICD_OP_FILE_INVERT,
        cicd_pkg::CICD_OP_FILE_DECREMENT: z_q <= alu_bus.zero;
        default: z_q <= z_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= '0;
    end else if (wdt_restart) begin
      pre_q <= '0;
    end else if (watchdog_tick) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdt_q <= `CICD_WDT_CLEAR;
    end else if (wdt_restart) begin
      wdt_q <= `CICD_WDT_CLEAR;
    end else if (pre_wrap) begin
      wdt_q <= wdt_q + 8'h01;
    end
  end

  // expiry flag set by restart
  // Expiry pulls the flag low at counter rollover
  always_ff @(posedge mclk) begin
    if (rst) begin
      to_n_q <= 1'b1;
    end else if (wdt_restart) begin
      to_n_q <= 1'b1;
    end else if (pre_wrap && (&wdt_q)) begin
      to_n_q <= 1'b0;
    end
  end

  // sleep flag set by restart
  // Sleep entry is outside this block; only restart touches it here
  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_n_q <= 1'b1;
    end else if (wdt_restart) begin
      pd_n_q <= 1'b1;
    end
  end

  // Skip marker for the fetch stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= take && is_skip;
    end
  end

  assign pc = pc_q;
  assign accumulator = acc_q;
  assign zero_flag = z_q;
  assign watchdog_expiry_flag_n = to_n_q;
  assign sleep_entry_flag_n = pd_n_q;
  assign watchdog_counter = wdt_q;
  assign watchdog_prescaler = pre_q;
  assign file_we = we_q;
  assign file_waddr = waddr_q;
  assign file_wdata = wdata_q;
  assign stack_push = push_q;
  assign return_stack_top = tos_q;
  assign skip_next = skip_q;
endmodule : cicd_core

// ---- rtl/cicd_params.svh ----
`ifndef CICD_PARAMS_SVH
`define CICD_PARAMS_SVH
`define CICD_PC_W 15
`define CICD_LIT_W 11
`define CICD_FADDR_W 7
`define CICD_WDT_W 8
`define CICD_PRE_W 8
`define CICD_WDT_CLEAR 8'h00
`define CICD_PC_RESET 15'h0000
`define CICD_ACC_RESET 8'h00
`define CICD_ZERO_BYTE 8'h00
`define CICD_LIT_HI 10
`define CICD_LATCH_CALL_HI 6
`define CICD_LATCH_CALL_LO 3
`define CICD_LATCH_ACALL_HI 6
`define CICD_FULL_CYCLES 2'h2
`endif

// ---- rtl/cicd_pkg.sv ----
package cicd_pkg;
  typedef enum logic [3:0] {
    CICD_OP_NONE,
    CICD_OP_SUBROUTINE_JUMP_LIT,
    CICD_OP_SUBROUTINE_JUMP_ACC,
    CICD_OP_WATCHDOG_RESTART,
    CICD_OP_FILE_ZERO,
    CICD_OP_ACCUMULATOR_ZERO,
    CICD_OP_FILE_INVERT,
    CICD_OP_FILE_DECREMENT,
    CICD_OP_FILE_DECREMENT_SKIP
  } cicd_op_type;
  typedef enum logic [1:0] {
    CICD_ST_IDLE,
    CICD_ST_SECOND
  } cicd_state_type;
endpackage : cicd_pkg

// ---- rtl/cicd_alu_if.sv ----
`timescale 1ns/1ps
interface cicd_alu_if;
  cicd_pkg::cicd_op_type op;
  logic [7:0] operand;
  logic [7:0] result;
  logic zero;
  modport core (output op, output operand, input result, input zero);
  modport alu (input op, input operand, output result, output zero);
endinterface : cicd_alu_if

// ---- rtl/cicd_alu.sv ----
`timescale 1ns/1ps
`include "cicd_params.svh"
module cicd_alu (
  cicd_alu_if.alu a
);
  always_comb begin
    case (a.op)
      cicd_pkg::CICD_OP_FILE_ZERO,
      cicd_pkg::CICD_OP_ACCUMULATOR_ZERO: a.result = `CICD_ZERO_BYTE;
      cicd_pkg::CICD_OP_FILE_INVERT: a.result = ~a.operand;
      cicd_pkg::CICD_OP_FILE_DECREMENT,
      cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP: a.result = a.operand - 8'h01;
      default: a.result = a.operand;
    endcase
    a.zero = (a.result == `CICD_ZERO_BYTE);
  end
endmodule : cicd_alu

// ---- verif/cicd_core_properties.sv ----
`timescale 1ns/1ps
module cicd_core_properties #(
  parameter int PC_W = 15
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic issue_valid,
  input cicd_pkg::cicd_op_type issue_op,
  input wire logic [10:0] issue_literal,
  input wire logic issue_dest,
  input wire logic issue_ready,
  input wire logic [7:0] pc_upper_latch,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] return_stack_top,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag,
  input wire logic watchdog_expiry_flag_n,
  input wire logic sleep_entry_flag_n,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] watchdog_prescaler,
  input wire logic skip_next
);
  wire tk = issue_valid && issue_ready;
  wire t_lit = tk && issue_op == cicd_pkg::CICD_OP_SUBROUTINE_JUMP_LIT;
  wire t_acc = tk && issue_op == cicd_pkg::CICD_OP_SUBROUTINE_JUMP_ACC;
  wire t_wdt = tk && issue_op == cicd_pkg::CICD_OP_WATCHDOG_RESTART;
  wire t_fz = tk && issue_op == cicd_pkg::CICD_OP_FILE_ZERO;
  wire t_az = tk && issue_op == cicd_pkg::CICD_OP_ACCUMULATOR_ZERO;
  wire t_inv = tk && issue_op == cicd_pkg::CICD_OP_FILE_INVERT && !issue_dest;
  wire t_dec = tk && issue_op == cicd_pkg::CICD_OP_FILE_DECREMENT && issue_dest;
  wire t_dsk = tk && issue_op == cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_call_push: assert property ((t_lit || t_acc) |=> stack_push && $stable(zero_flag) &&
    return_stack_top == PC_W'($past(pc) + 1))
    else $error("call push wrong");
  chk_lit_target: assert property (t_lit |=>
    pc == {$past(pc_upper_latch[6:3]), $past(issue_literal)})
    else $error("literal call target wrong");
  chk_lit_cycles: assert property (t_lit |=> !issue_ready ##1 issue_ready)
    else $error("literal call length wrong");
  chk_acc_target: assert property (t_acc |=>
    pc == {$past(pc_upper_latch[6:0]), $past(accumulator)})
    else $error("accumulator call target wrong");
  chk_acc_cycles: assert property (t_acc |=> !issue_ready ##1 issue_ready)
    else $error("accumulator call length wrong");
  chk_wdt_restart: assert property (t_wdt |=> watchdog_counter == 8'h00 &&
    watchdog_prescaler == 8'h00 && watchdog_expiry_flag_n && sleep_entry_flag_n)
    else $error("watchdog restart wrong");
  chk_file_zero: assert property (t_fz |=> file_we && file_wdata == 8'h00 && zero_flag)
    else $error("file clear wrong");
  chk_acc_zero: assert property (t_az |=> accumulator == 8'h00 && zero_flag)
    else $error("accumulator clear wrong");
  chk_invert_acc: assert property (t_inv |=> accumulator == ~$past(file_rdata) &&
    zero_flag == (accumulator == 8'h00))
    else $error("invert wrong");
  chk_dec_file: assert property (t_dec |=> file_we &&
    file_wdata == 8'($past(file_rdata) - 8'h01))
    else $error("decrement wrong");
  chk_skip_flag: assert property (t_dsk |=> $stable(zero_flag) &&
    skip_next == ($past(file_rdata) == 8'h01))
    else $error("decrement skip wrong");
endmodule : cicd_core_properties
bind cicd_core cicd_core_properties #(.PC_W(PC_W)) i_chk (.*);

// ---- verif/cicd_core_tb.sv ----
`timescale 1ns/1ps
module cicd_core_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  cicd_pkg::cicd_op_type issue_op = cicd_pkg::CICD_OP_NONE;
  logic [10:0] issue_literal = 11'h000;
  logic [6:0] issue_faddr = 7'h00;
  logic issue_dest = 1'b0;
  logic [7:0] pc_upper_latch = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic watchdog_tick = 1'b0;
  logic issue_ready, file_we, stack_push, skip_next, zero_flag;
  logic watchdog_expiry_flag_n, sleep_entry_flag_n;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata, accumulator, watchdog_counter, watchdog_prescaler;
  logic [14:0] return_stack_top, pc;
  logic [14:0] m_pc = 15'h0000;
  logic [7:0] m_acc = 8'h00;
  logic m_z = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  always #2 mclk = ~mclk;
  cicd_core i_cicd_core (.*);
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input cicd_pkg::cicd_op_type op, input logic [10:0] lit,
    input logic d, input logic [7:0] fr, input logic [7:0] lt);
    logic [7:0] r;
    logic two;
    issue_op = op;
    issue_literal = lit;
    issue_faddr = lit[6:0];
    issue_dest = d;
    file_rdata = fr;
    pc_upper_latch = lt;
    issue_valid = 1'b1;
    @(negedge mclk);
    issue_valid = 1'b0;
    two = 1'b0;
    r = fr - 8'h01;
    m_pc = m_pc + 15'h0001;
    case (op)
      cicd_pkg::CICD_OP_SUBROUTINE_JUMP_LIT, cicd_pkg::CICD_OP_SUBROUTINE_JUMP_ACC: begin
        check(stack_push, 1'b1);
        check(return_stack_top, m_pc);
        m_pc = (op == cicd_pkg::CICD_OP_SUBROUTINE_JUMP_LIT) ? {lt[6:3], lit} : {lt[6:0], m_acc};
        two = 1'b1;
      end
      cicd_pkg::CICD_OP_WATCHDOG_RESTART: begin
        check(watchdog_counter, 8'h00);
        check(watchdog_prescaler, 8'h00);
        check({watchdog_expiry_flag_n, sleep_entry_flag_n}, 2'h3);
      end
      cicd_pkg::CICD_OP_FILE_ZERO: begin
        check(file_we, 1'b1);
        check(file_waddr, lit[6:0]);
        check(file_wdata, 8'h00);
        m_z = 1'b1;
      end
      cicd_pkg::CICD_OP_ACCUMULATOR_ZERO: begin
        m_acc = 8'h00;
        m_z = 1'b1;
      end
      default: begin
        if (op == cicd_pkg::CICD_OP_FILE_INVERT) r = ~fr;
        if (op != cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP) m_z = (r == 8'h00);
        else begin
          check(skip_next, r == 8'h00);
          if (r == 8'h00) begin
            m_pc = m_pc + 15'h0001;
            two = 1'b1;
          end
        end
        if (d) begin
          check(file_we, 1'b1);
          check(file_waddr, lit[6:0]);
          check(file_wdata, r);
        end else begin
          check(file_we, 1'b0);
          m_acc = r;
        end
      end
    endcase
    check(pc, m_pc);
    check(accumulator, m_acc);
    check(zero_flag, m_z);
    check(issue_ready, !two);
    if (two) @(negedge mclk);
  endtask : run
  task end_sim;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(32'he81b));
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    watchdog_tick = 1'b1;
    repeat (5) @(negedge mclk);
    watchdog_tick = 1'b0;
    check(watchdog_prescaler, 8'h05);
    run(cicd_pkg::CICD_OP_WATCHDOG_RESTART, 11'h000, 1'b0, 8'h00, 8'h00);
    run(cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP, 11'h07f, 1'b1, 8'h01, 8'h00);
    run(cicd_pkg::CICD_OP_FILE_DECREMENT_SKIP, 11'h000, 1'b0, 8'h01, 8'h00);
    run(cicd_pkg::CICD_OP_FILE_DECREMENT, 11'h011, 1'b1, 8'h00, 8'h00);
    run(cicd_pkg::CICD_OP_FILE_INVERT, 11'h022, 1'b0, 8'hff, 8'h00);
    run(cicd_pkg::CICD_OP_SUBROUTINE_JUMP_LIT, 11'h7ff, 1'b0, 8'h00, 8'hff);
    run(cicd_pkg::CICD_OP_SUBROUTINE_JUMP_ACC, 11'h000, 1'b0, 8'h00, 8'h7f);
    for (int i = 0; i < 300; i++) begin
      run(cicd_pkg::cicd_op_type'(4'(1 + $urandom % 8)), 11'($urandom), 1'($urandom),
        8'($urandom), 8'($urandom));
    end
    end_sim;
  end
  initial begin
    #20000;
    fail_count++;
    end_sim;
  end
endmodule : cicd_core_tb
